/* bms_top.sv */
// Boot mode selector, status lamp and sensor repeater
`timescale 1ns/1ps
`default_nettype none

module bms_top
  import bms_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Boot push button pin, high while pressed
  input wire logic boot_btn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Application state from the memory system
  input wire logic ram_app_present,
  input wire logic ram_app_ck_ok,
  input wire logic flash_app_present,
  // Mode and control outputs
  output bms_mode_type mode,
  output logic lamp_out,
  output logic app_start,
  output logic app_from_flash,
  output logic cold_init,
  output logic lock_active,
  output logic fw_load_en_a,
  output logic fw_load_en_b,
  // Effective serial parameters
  output logic [19:0] sensor_div,
  output logic sensor_en,
  output logic [19:0] port_a_div,
  output logic [1:0] port_a_parity,
  output logic port_a_seven,
  output logic port_a_two_stop,
  output logic port_a_en,
  output logic [19:0] port_b_div,
  output logic [1:0] port_b_parity,
  output logic port_b_seven,
  output logic port_b_two_stop,
  output logic port_b_en,
  // Repeater: port A to sensor port
  input wire logic [7:0] a_rx_data,
  input wire logic a_rx_valid,
  output logic [7:0] s_tx_data,
  output logic s_tx_valid,
  input wire logic s_tx_ready,
  // Repeater: sensor port to port A
  input wire logic [7:0] s_rx_data,
  input wire logic s_rx_valid,
  output logic [7:0] a_tx_data,
  output logic a_tx_valid,
  input wire logic a_tx_ready
);

  // ==========================================================
  // Millisecond tick
  logic [31:0] tick_cnt;
  logic ms_tick;

  always_ff @(posedge mclk) begin
    if (rst || tick_cnt == 32'(MS_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign ms_tick = (tick_cnt == 32'(MS_CYCLES - 1));

  // ==========================================================
  // Button synchroniser and debouncer
  logic btn_s1, btn_s2, btn_db;
  logic [19:0] deb_cnt;

  always_ff @(posedge mclk) begin
    btn_s1 <= boot_btn;
    btn_s2 <= btn_s1;
  end

  // Level accepted after DEB_MS of stability
  always_ff @(posedge mclk) begin
    if (rst) begin
      btn_db <= 1'b0;
      deb_cnt <= '0;
    end else if (btn_s2 == btn_db) begin
      deb_cnt <= '0;
    end else if (ms_tick) begin
      deb_cnt <= deb_cnt + 20'h1;
      if (deb_cnt >= DEB_MS) begin
        btn_db <= btn_s2;
      end
    end
  end

  // ==========================================================
  // Hold timer since reset release, saturating
  logic [19:0] elapsed;

  always_ff @(posedge mclk) begin
    if (rst) begin
      elapsed <= '0;
    end else if (ms_tick && elapsed != 20'hfffff) begin
      elapsed <= elapsed + 20'h1;
    end
  end

  // ==========================================================
  // Boot selection; once chosen the mode is final
  logic hold_rel;
  assign hold_rel = (mode == MODE_HOLD) && !btn_db;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= MODE_PEND;
    end else begin
      unique case (mode)
        MODE_PEND: begin
          if (elapsed >= SETTLE_MS) begin
            mode <= btn_db ? MODE_HOLD : MODE_RUN;
          end
        end
        MODE_HOLD: begin
          if (!btn_db) begin
            if (elapsed < SOLID_MS) begin
              mode <= MODE_RUN;
            end else if (elapsed < RAPID_MS) begin
              mode <= MODE_SERVICE;
            end else if (elapsed <= SLOW_MS) begin
              mode <= MODE_SENSOR;
            end else begin
              mode <= MODE_COLD;
            end
          end
        end
        MODE_RUN, MODE_SERVICE, MODE_SENSOR, MODE_COLD: begin
          mode <= mode;
        end
      endcase
    end
  end

  // One pulse when Cold Boot is entered
  always_ff @(posedge mclk) begin
    if (rst) begin
      cold_init <= 1'b0;
    end else begin
      cold_init <= hold_rel && elapsed > SLOW_MS;
    end
  end

  // ==========================================================
  // Registers
  logic [CFG_W-1:0] cfg_a, cfg_b;
  logic lamp_default, power_state, lock_reg;
  logic [31:0] lamp_tmo, tmo_cnt;
  logic [15:0] alarm_code;
  logic defaults_now;
  assign defaults_now = hold_rel && elapsed >= SOLID_MS &&
                        (elapsed < RAPID_MS || elapsed > SLOW_MS);

  // Port configuration, defaults restored on service or cold boot
  always_ff @(posedge mclk) begin
    if (rst || defaults_now) begin
      cfg_a <= CFG_A_RST;
      cfg_b <= CFG_B_RST;
    end else if (reg_wr && reg_addr == CFG_A_OFS) begin
      cfg_a <= reg_wdata[CFG_W-1:0];
    end else if (reg_wr && reg_addr == CFG_B_OFS) begin
      cfg_b <= reg_wdata[CFG_W-1:0];
    end
  end

  // Lamp settings and alarm code
  always_ff @(posedge mclk) begin
    if (rst) begin
      lamp_default <= 1'b0;
      lamp_tmo <= LAMP_TMO_RST;
      alarm_code <= '0;
    end else if (reg_wr) begin
      if (reg_addr == LAMP_OFS) begin
        lamp_default <= reg_wdata[0];
      end
      if (reg_addr == TMO_OFS) begin
        lamp_tmo <= reg_wdata;
      end
      if (reg_addr == ALARM_OFS) begin
        alarm_code <= reg_wdata[15:0];
      end
    end
  end

  // Lock, cleared by cold boot
  always_ff @(posedge mclk) begin
    if (rst || cold_init) begin
      lock_reg <= 1'b0;
    end else if (reg_wr && reg_addr == LOCK_OFS) begin
      lock_reg <= reg_wdata[0];
    end
  end

  // Lamp power state returns to default after timeout
  always_ff @(posedge mclk) begin
    if (rst) begin
      power_state <= 1'b0;
      tmo_cnt <= '0;
    end else if (reg_wr && reg_addr == LAMP_OFS) begin
      power_state <= reg_wdata[1];
      tmo_cnt <= lamp_tmo;
    end else if (power_state != lamp_default) begin
      if (tmo_cnt == '0) begin
        power_state <= lamp_default;
      end else if (ms_tick) begin
        tmo_cnt <= tmo_cnt - 32'h1;
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CFG_A_OFS: reg_rdata <= {25'h0, cfg_a};
        CFG_B_OFS: reg_rdata <= {25'h0, cfg_b};
        LAMP_OFS: reg_rdata <= {30'h0, power_state, lamp_default};
        TMO_OFS: reg_rdata <= lamp_tmo;
        ALARM_OFS: reg_rdata <= {16'h0, alarm_code};
        LOCK_OFS: reg_rdata <= {31'h0, lock_reg};
        STAT_OFS: reg_rdata <= {27'h0, lamp_out, lock_active, mode};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Effective serial parameters per mode
  logic run_m, sens_m, dflt_m;
  assign run_m = (mode == MODE_RUN);
  assign sens_m = (mode == MODE_SENSOR);
  assign dflt_m = (mode == MODE_SERVICE) || (mode == MODE_COLD);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sensor_div <= SENSOR_DIV;
      sensor_en <= 1'b0;
      port_a_div <= bms_div_a(CFG_A_RST[2:0]);
      port_a_parity <= PAR_NONE;
      port_a_seven <= 1'b0;
      port_a_two_stop <= 1'b0;
      port_a_en <= 1'b0;
      port_b_div <= bms_div_b(CFG_B_RST[2:0]);
      port_b_parity <= PAR_NONE;
      port_b_seven <= 1'b0;
      port_b_two_stop <= 1'b0;
      port_b_en <= 1'b0;
    end else if (sens_m) begin
      sensor_en <= 1'b1;
      port_a_div <= SENSOR_DIV;
      port_a_parity <= PAR_NONE;
      port_a_seven <= 1'b0;
      port_a_two_stop <= 1'b0;
      port_a_en <= 1'b1;
      port_b_en <= 1'b0;
    end else begin
      sensor_en <= run_m || dflt_m;
      port_a_div <= bms_div_a(cfg_a[2:0]);
      port_a_parity <= cfg_a[4:3];
      port_a_seven <= cfg_a[5];
      port_a_two_stop <= cfg_a[6];
      port_a_en <= run_m || dflt_m;
      port_b_div <= bms_div_b(cfg_b[2:0]);
      port_b_parity <= cfg_b[4:3];
      port_b_seven <= cfg_b[5];
      port_b_two_stop <= cfg_b[6];
      port_b_en <= run_m || dflt_m;
    end
  end

  // ==========================================================
  // Application start, lock and firmware loading
  always_ff @(posedge mclk) begin
    if (rst) begin
      app_start <= 1'b0;
      app_from_flash <= 1'b0;
      lock_active <= 1'b0;
      fw_load_en_a <= 1'b0;
      fw_load_en_b <= 1'b0;
    end else begin
      app_start <= run_m && (ram_app_present ? ram_app_ck_ok
                                             : flash_app_present);
      app_from_flash <= run_m && !ram_app_present && flash_app_present;
      lock_active <= lock_reg && (run_m || mode == MODE_SERVICE);
      fw_load_en_a <= run_m || dflt_m;
      fw_load_en_b <= 1'b0;
    end
  end

  // ==========================================================
  // Serial flash sequencer for alarm and sensor patterns
  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} bms_fl_type;
  bms_fl_type fl_state;
  logic [15:0] show_code, seq_code;
  logic [4:0] seq_len, seq_idx;
  logic [19:0] ph_cnt;
  logic seq_lamp, sel_lamp;

  // Number of bits with leading zeros dropped
  function automatic logic [4:0] bms_len(input logic [15:0] c);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) begin
      if (c[i]) begin
        n = 5'(i + 1);
      end
    end
    return n;
  endfunction

  assign show_code = sens_m ? SENSOR_CODE : alarm_code;

  always_ff @(posedge mclk) begin
    if (rst || mode == MODE_PEND || mode == MODE_HOLD) begin
      fl_state <= FL_IDLE;
      seq_code <= '0;
      seq_len <= '0;
      seq_idx <= '0;
      ph_cnt <= '0;
    end else begin
      unique case (fl_state)
        FL_IDLE: begin
          if (show_code != '0) begin
            fl_state <= FL_ON;
            seq_code <= show_code;
            seq_len <= bms_len(show_code);
            seq_idx <= '0;
            ph_cnt <= '0;
          end
        end
        FL_ON: begin
          if (ms_tick) begin
            ph_cnt <= ph_cnt + 20'h1;
            if (ph_cnt >= (seq_code[seq_idx[3:0]] ? LONG_MS
                                                   : SHORT_MS)) begin
              fl_state <= FL_OFF;
              ph_cnt <= '0;
            end
          end
        end
        FL_OFF: begin
          if (ms_tick) begin
            ph_cnt <= ph_cnt + 20'h1;
            if (ph_cnt >= SPACE_MS) begin
              ph_cnt <= '0;
              seq_idx <= seq_idx + 5'h1;
              fl_state <= (seq_idx + 5'h1 == seq_len) ? FL_GAP : FL_ON;
            end
          end
        end
        FL_GAP: begin
          if (ms_tick) begin
            ph_cnt <= ph_cnt + 20'h1;
            if (ph_cnt >= GAP_MS) begin
              fl_state <= FL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Selection progress indication while the button is held
  always_comb begin
    sel_lamp = 1'b0;
    if (elapsed > SLOW_MS) begin
      sel_lamp = elapsed[SLOW_BIT];
    end else if (elapsed >= RAPID_MS) begin
      sel_lamp = elapsed[RAPID_BIT];
    end else if (elapsed >= SOLID_MS) begin
      sel_lamp = 1'b1;
    end
  end
  assign seq_lamp = (fl_state == FL_ON);

  always_ff @(posedge mclk) begin
    if (rst) begin
      lamp_out <= 1'b0;
    end else if (mode == MODE_HOLD) begin
      lamp_out <= sel_lamp;
    end else begin
      lamp_out <= seq_lamp && (sens_m || power_state);
    end
  end

  // ==========================================================
  // Sensor mode repeater
  logic [3:0] idle_cnt, gap_cnt;
  logic s_full, a_full, a_first;
  assign a_first = (idle_cnt >= MSG_IDLE_MS);

  // Idle time on port A marks a new message
  always_ff @(posedge mclk) begin
    if (rst || a_rx_valid) begin
      idle_cnt <= rst ? MSG_IDLE_MS : 4'h0;
    end else if (ms_tick && !a_first) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // Byte towards the sensor, lead FF dropped
  always_ff @(posedge mclk) begin
    if (rst || !sens_m) begin
      s_full <= 1'b0;
      s_tx_data <= '0;
    end else if (a_rx_valid && !s_full &&
                 !(a_first && a_rx_data == LEAD_BYTE)) begin
      s_full <= 1'b1;
      s_tx_data <= a_rx_data;
    end else if (s_tx_valid && s_tx_ready) begin
      s_full <= 1'b0;
    end
  end

  // Spacing between bytes sent to the sensor
  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_cnt <= '0;
    end else if (s_tx_valid && s_tx_ready) begin
      gap_cnt <= SENSOR_GAP_MS;
    end else if (ms_tick && gap_cnt != '0) begin
      gap_cnt <= gap_cnt - 4'h1;
    end
  end
  assign s_tx_valid = s_full && gap_cnt == '0;

  // Byte from the sensor passed unchanged
  always_ff @(posedge mclk) begin
    if (rst || !sens_m) begin
      a_full <= 1'b0;
      a_tx_data <= '0;
    end else if (s_rx_valid && !a_full) begin
      a_full <= 1'b1;
      a_tx_data <= s_rx_data;
    end else if (a_tx_valid && a_tx_ready) begin
      a_full <= 1'b0;
    end
  end
  assign a_tx_valid = a_full;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_run_release: assert property (hold_rel && elapsed < SOLID_MS
    |=> mode == MODE_RUN) else $error("early release not run");
  a_service_release: assert property (hold_rel && elapsed >= SOLID_MS &&
    elapsed < RAPID_MS |=> mode == MODE_SERVICE)
    else $error("service not chosen");
  a_sensor_release: assert property (hold_rel && elapsed >= RAPID_MS &&
    elapsed <= SLOW_MS |=> mode == MODE_SENSOR)
    else $error("sensor not chosen");
  a_cold_release: assert property (hold_rel && elapsed > SLOW_MS
    |=> mode == MODE_COLD && cold_init)
    else $error("cold boot not chosen");
  a_solid_lamp: assert property (mode == MODE_HOLD && elapsed >= SOLID_MS
    && elapsed < RAPID_MS ##1 mode == MODE_HOLD |-> lamp_out)
    else $error("lamp not solid");
  a_mode_kept: assert property (mode inside {MODE_RUN, MODE_SERVICE,
    MODE_SENSOR, MODE_COLD} |=> $stable(mode))
    else $error("mode changed after selection");
  a_sensor_cfg: assert property (sens_m ##1 sens_m |-> !port_b_en &&
    port_a_div == SENSOR_DIV && port_a_parity == PAR_NONE)
    else $error("sensor port setup wrong");
  a_ff_drop: assert property (sens_m && a_rx_valid && a_first &&
    a_rx_data == LEAD_BYTE && !s_full |=> !s_full)
    else $error("lead byte forwarded");
  a_pace_gap: assert property (s_tx_valid && s_tx_ready
    |=> !s_tx_valid [*3]) else $error("sensor byte too soon");
  a_default_cfg: assert property (dflt_m ##1 dflt_m |-> port_a_en &&
    sensor_en && port_a_div == bms_div_a(cfg_a[2:0]))
    else $error("default setup wrong");
  a_app_start: assert property (run_m && !ram_app_present &&
    flash_app_present |=> app_start && app_from_flash)
    else $error("flash app not started");
  a_fw_port: assert property (!fw_load_en_b)
    else $error("firmware load on port b");
  a_cold_unlock: assert property (cold_init |=> !lock_reg)
    else $error("lock kept on cold boot");
  a_lamp_dark: assert property (fl_state == FL_IDLE && run_m ##1 run_m
    |-> !lamp_out) else $error("lamp lit without alarm");
  a_lamp_tmo: assert property (power_state != lamp_default &&
    tmo_cnt == '0 && !reg_wr |=> power_state == lamp_default)
    else $error("lamp timeout ignored");

  c_service: cover property (mode == MODE_HOLD ##1 mode == MODE_SERVICE);
  c_sensor: cover property (sens_m && s_tx_valid && s_tx_ready);
  c_alarm: cover property (fl_state == FL_GAP && run_m);

endmodule

`default_nettype wire

/* bms_pkg.sv */
// Package of constants and lookup functions for the boot mode selector
package bms_pkg;

  // ==========================================================
  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS = 1000000;
  localparam int MS_CYCLES_DFLT = NS_PER_MS / CLK_PERIOD_NS;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

  // ==========================================================
  // Button timing in milliseconds; all but DEB_MS count hold since reset release
  localparam logic [19:0] SOLID_MS = 20'd3000;
  localparam logic [19:0] RAPID_MS = 20'd15000;
  localparam logic [19:0] SLOW_MS = 20'd30000;
  localparam logic [19:0] DEB_MS = 20'd20;
  localparam logic [19:0] SETTLE_MS = 20'd22;
  localparam int RAPID_BIT = 6;
  localparam int SLOW_BIT = 9;

  // ==========================================================
  // Lamp flash timing in milliseconds
  localparam logic [19:0] SHORT_MS = 20'd200;
  localparam logic [19:0] LONG_MS = 20'd600;
  localparam logic [19:0] SPACE_MS = 20'd300;
  localparam logic [19:0] GAP_MS = 20'd1000;
  localparam logic [31:0] LAMP_TMO_RST = 32'h000493e0;
  localparam logic [15:0] SENSOR_CODE = 16'h0004;

  // ==========================================================
  // Repeater timing in milliseconds
  localparam logic [3:0] MSG_IDLE_MS = 4'h5;
  localparam logic [3:0] SENSOR_GAP_MS = 4'h3;
  localparam logic [7:0] LEAD_BYTE = 8'hff;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] CFG_A_OFS = 4'h0;
  localparam logic [3:0] CFG_B_OFS = 4'h1;
  localparam logic [3:0] LAMP_OFS = 4'h2;
  localparam logic [3:0] TMO_OFS = 4'h3;
  localparam logic [3:0] ALARM_OFS = 4'h4;
  localparam logic [3:0] LOCK_OFS = 4'h5;
  localparam logic [3:0] STAT_OFS = 4'h6;

  // ==========================================================
  // Port config fields: baud idx [2:0], parity [4:3], 7 bits [5], 2 stop [6]
  localparam int CFG_W = 7;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [CFG_W-1:0] CFG_A_RST = 7'h05;
  localparam logic [CFG_W-1:0] CFG_B_RST = 7'h03;

  typedef enum logic [2:0] {
    MODE_PEND, MODE_HOLD, MODE_RUN, MODE_SERVICE, MODE_SENSOR, MODE_COLD
  } bms_mode_type;

  // Port A divisor: 300 baud doubling up to 38400
  function automatic logic [19:0] bms_div_a(input logic [2:0] idx);
    logic [19:0] d;
    d = 20'(CLK_HZ / 38400);
    case (idx)
      3'h0: d = 20'(CLK_HZ / 300);
      3'h1: d = 20'(CLK_HZ / 600);
      3'h2: d = 20'(CLK_HZ / 1200);
      3'h3: d = 20'(CLK_HZ / 2400);
      3'h4: d = 20'(CLK_HZ / 4800);
      3'h5: d = 20'(CLK_HZ / 9600);
      3'h6: d = 20'(CLK_HZ / 19200);
      default: d = 20'(CLK_HZ / 38400);
    endcase
    return d;
  endfunction

  // Port B divisor: 1200 baud up to 115200
  function automatic logic [19:0] bms_div_b(input logic [2:0] idx);
    logic [19:0] d;
    d = 20'(CLK_HZ / 115200);
    case (idx)
      3'h0: d = 20'(CLK_HZ / 1200);
      3'h1: d = 20'(CLK_HZ / 2400);
      3'h2: d = 20'(CLK_HZ / 4800);
      3'h3: d = 20'(CLK_HZ / 9600);
      3'h4: d = 20'(CLK_HZ / 19200);
      3'h5: d = 20'(CLK_HZ / 38400);
      3'h6: d = 20'(CLK_HZ / 57600);
      default: d = 20'(CLK_HZ / 115200);
    endcase
    return d;
  endfunction

  localparam logic [19:0] SENSOR_DIV = 20'(CLK_HZ / 4800);

endpackage

/* bms_far.sv */
// Far side model: sensor electronics and a host on user port A
`timescale 1ns/1ps
`default_nettype none
module bms_far (
  // Clock
  input wire logic mclk,
  // Sensor port
  input wire logic [7:0] s_tx_data,
  input wire logic s_tx_valid,
  output logic s_tx_ready,
  output logic [7:0] s_rx_data,
  output logic s_rx_valid,
  // Host on port A
  input wire logic [7:0] a_tx_data,
  input wire logic a_tx_valid,
  output logic a_tx_ready,
  output logic [7:0] a_rx_data,
  output logic a_rx_valid
);
  logic [7:0] s_got[$];
  logic [7:0] a_got[$];
  int s_at[$];
  int t = 0;
  int w = 0;
  bit slow = 0;

  // Idle lines show no stale byte
  initial begin
    s_tx_ready = 1'b0;
    a_tx_ready = 1'b0;
    s_rx_data = 8'h5a;
    s_rx_valid = 1'b0;
    a_rx_data = 8'ha5;
    a_rx_valid = 1'b0;
  end

  // Sensor takes bytes, alternately at once and after a stall
  always @(posedge mclk) begin
    t <= t + 1;
    if (s_tx_valid && s_tx_ready) begin
      s_got.push_back(s_tx_data);
      s_at.push_back(t);
      slow <= !slow;
      w <= 0;
      s_tx_ready <= 1'b0;
    end else if (s_tx_valid) begin
      w <= w + 1;
      s_tx_ready <= (w >= (slow ? 6 : 0));
    end
  end

  // Host takes returned bytes promptly
  always @(posedge mclk) begin
    if (a_tx_valid && a_tx_ready)
      a_got.push_back(a_tx_data);
    a_tx_ready <= a_tx_valid && !a_tx_ready;
  end

  // One byte received on port A
  task automatic put_a(input logic [7:0] b);
    @(posedge mclk);
    a_rx_data <= b;
    a_rx_valid <= 1'b1;
    @(posedge mclk);
    a_rx_valid <= 1'b0;
    a_rx_data <= ~b;
  endtask

  // One byte sent by the sensor
  task automatic put_s(input logic [7:0] b);
    @(posedge mclk);
    s_rx_data <= b;
    s_rx_valid <= 1'b1;
    @(posedge mclk);
    s_rx_valid <= 1'b0;
    s_rx_data <= ~b;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Testbench for the boot mode selector and sensor repeater
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bms_pkg::*;
  localparam int MSC = 1;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic boot_btn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ram_p = 1'b0;
  logic ram_ok = 1'b0;
  logic fl_p = 1'b1;
  wire logic [31:0] reg_rdata;
  bms_mode_type mode;
  wire logic lamp_out, app_start, app_from_flash, fw_a, fw_b;
  wire logic sensor_en, port_b_en, cold_p, lock_act, b_seven, b_two;
  wire logic [1:0] b_par;
  wire logic [19:0] sensor_div, port_a_div, port_b_div;
  wire logic [7:0] a_rx_data, s_tx_data, s_rx_data, a_tx_data;
  wire logic a_rx_valid, s_tx_valid, s_tx_ready;
  wire logic s_rx_valid, a_tx_valid, a_tx_ready;
  int fails = 0;
  int total_checks = 0;
  int cold_n = 0;
  int cyc = 0;
  int n;
  logic lit;

  bms_top #(.MS_CYCLES(MSC)) i_bms_top (
    .mclk, .rst, .boot_btn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ram_app_present(ram_p), .ram_app_ck_ok(ram_ok),
    .flash_app_present(fl_p), .mode, .lamp_out, .app_start,
    .app_from_flash, .cold_init(cold_p), .lock_active(lock_act),
    .fw_load_en_a(fw_a), .fw_load_en_b(fw_b), .sensor_div, .sensor_en,
    .port_a_div, .port_a_parity(), .port_a_seven(), .port_a_two_stop(),
    .port_a_en(), .port_b_div, .port_b_parity(b_par),
    .port_b_seven(b_seven), .port_b_two_stop(b_two),
    .port_b_en, .a_rx_data, .a_rx_valid, .s_tx_data, .s_tx_valid,
    .s_tx_ready, .s_rx_data, .s_rx_valid, .a_tx_data, .a_tx_valid,
    .a_tx_ready);

  bms_far i_bms_far (
    .mclk, .s_tx_data, .s_tx_valid, .s_tx_ready, .s_rx_data, .s_rx_valid,
    .a_tx_data, .a_tx_valid, .a_tx_ready, .a_rx_data, .a_rx_valid);

  // Cold boot pulses seen
  always @(negedge mclk) begin
    cold_n += cold_p;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic do_reset(input logic held);
    @(posedge mclk);
    rst <= 1'b1;
    boot_btn <= held;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
  endtask

  task automatic ms(input int k);
    repeat (k * MSC) @(posedge mclk);
  endtask

  task automatic wait_q(input bit host, input int cnt);
    n = 0;
    while ((host ? i_bms_far.a_got.size() : i_bms_far.s_got.size()) < cnt
           && n < 500) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // Length in cycles of the next lamp flash
  task automatic flash_len;
    n = 0;
    while (lamp_out !== 1'b1 && n < 12000) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (lamp_out === 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_run;
    do_reset(1'b0);
    ms(40);
    #1 chk(mode, MODE_RUN);
    chk(port_a_div, 20'h065b9);
    chk({fw_a, fw_b}, 2'h2);
    chk({app_start, app_from_flash}, 2'h3);
    wr(CFG_A_OFS, 32'h0);
    wr(CFG_B_OFS, 32'h77);
    rd(CFG_A_OFS, 32'h0);
    rd(4'hf, 32'h0);
    chk(port_a_div, 20'hcb735);
    chk(port_b_div, 20'h0087a);
    chk({b_par, b_seven, b_two}, 4'hb);
    lit = 1'b0;
    repeat (400) begin
      @(negedge mclk);
      lit = lit | lamp_out;
    end
    chk(lit, 1'h0);
    rd(TMO_OFS, 32'h000493e0);
    wr(ALARM_OFS, 32'h1);
    wr(LAMP_OFS, 32'h3);
    flash_len();
    chk(n >= 597 && n <= 605, 1'h1);
    wr(TMO_OFS, 32'h20);
    wr(LAMP_OFS, 32'h2);
    rd(LAMP_OFS, 32'h2);
    ms(40);
    rd(LAMP_OFS, 32'h0);
    @(posedge mclk) {ram_p, ram_ok} <= 2'h2;
    ms(2);
    #1 chk({app_start, app_from_flash}, 2'h0);
    @(posedge mclk) ram_ok <= 1'b1;
    ms(2);
    #1 chk({app_start, app_from_flash}, 2'h2);
  endtask

  task automatic t_service;
    do_reset(1'b1);
    ms(1000);
    #1 chk(lamp_out, 1'h0);
    wr(CFG_A_OFS, 32'h0);
    ms(2300);
    #1 chk(lamp_out, 1'h1);
    ms(200);
    @(posedge mclk) boot_btn <= 1'b0;
    ms(40);
    #1 chk(mode, MODE_SERVICE);
    chk({sensor_en, sensor_div}, {1'b1, 20'h0cb73});
    chk(port_a_div, 20'h065b9);
    wr(LOCK_OFS, 32'h1);
    ms(2);
    #1 chk(lock_act, 1'h1);
    @(posedge mclk) boot_btn <= 1'b1;
    ms(300);
    #1 chk(mode, MODE_SERVICE);
  endtask

  task automatic t_sensor;
    do_reset(1'b1);
    ms(15500);
    @(posedge mclk) boot_btn <= 1'b0;
    ms(40);
    #1 chk(mode, MODE_SENSOR);
    chk({sensor_en, port_a_div, port_b_en}, {1'b1, 20'h0cb73, 1'b0});
    flash_len();
    flash_len();
    chk(n >= 199 && n <= 203, 1'h1);
    flash_len();
    chk(n >= 597 && n <= 605, 1'h1);
    i_bms_far.put_a(8'hff);
    i_bms_far.put_a(8'h12);
    wait_q(1'b0, 1);
    i_bms_far.put_a(8'hff);
    wait_q(1'b0, 2);
    chk({i_bms_far.s_got[0], i_bms_far.s_got[1]}, 16'h12ff);
    chk(i_bms_far.s_at[1] - i_bms_far.s_at[0] >= 8, 1'h1);
    i_bms_far.put_s(8'h34);
    wait_q(1'b1, 1);
    chk(i_bms_far.a_got[0], 8'h34);
  endtask

  task automatic t_cold;
    do_reset(1'b1);
    ms(100);
    wr(LOCK_OFS, 32'h1);
    wr(CFG_B_OFS, 32'h0);
    ms(30000);
    @(posedge mclk) boot_btn <= 1'b0;
    ms(40);
    #1 chk(mode, MODE_COLD);
    chk(cold_n, 1);
    chk(port_b_div, 20'h065b9);
    rd(LOCK_OFS, 32'h0);
  endtask

  // ==========================================================
  // Control
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 70000) begin
      fails++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    t_run();
    t_service();
    t_sensor();
    t_cold();
    summarize();
  end
endmodule
`default_nettype wire
